// [rtl/sscr_cfg.svh]
// Offsets, field positions, reset values and widths of the switch controller
`ifndef SSCR_CFG_SVH
`define SSCR_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSCR_OFS_SWITCH_STATE  4'h0
`define SSCR_OFS_STATUS        4'h4
`define SSCR_OFS_CONTROL       4'h8
`define SSCR_OFS_UPDATE_COUNT  4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSCR_STAT_SELECTED     0
`define SSCR_STAT_PENDING      1
`define SSCR_STAT_CLK_LEVEL    2
`define SSCR_CTRL_OPEN_ALL     0

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define SSCR_WORD_BITS         8
`define SSCR_CNT_BITS          16
`define SSCR_ADDR_BITS         4
`define SSCR_DATA_BITS         32
`define SSCR_BE_BITS           4
`define SSCR_WORD_RST          8'h00
`define SSCR_CNT_RST           16'h0000
`define SSCR_DATA_RST          32'h0000_0000

`endif

// [rtl/sscr_pkg.sv]
// Types shared by the switch controller modules
package sscr_pkg;

    // Latch update sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_SELECTED,
        ST_PENDING
    } sscr_state_t;

endpackage

// [rtl/sscr_link_if.sv]
// Signals between the system side and the serial shifter
`timescale 1ns/1ps
interface sscr_link_if #(parameter int WORD_W = 8);
    logic              serialClk;
    logic              selectN;
    logic              serialIn;
    logic              supplyRstn;
    logic              serialOut;
    logic [WORD_W-1:0] word;

    modport shifter (input serialClk, input selectN, input serialIn, input supplyRstn,
                     output serialOut, output word);
    modport sys     (output serialClk, output selectN, output serialIn, output supplyRstn,
                     input serialOut, input word);
endinterface

// [rtl/sscr_shifter.sv]
// Serial shift register and serial output on the link clock
`timescale 1ns/1ps
`include "sscr_cfg.svh"
module sscr_shifter
    import sscr_pkg::*;
#(
    parameter int WORD_W = `SSCR_WORD_BITS
)
(
    sscr_link_if.shifter lnk    // Link pins and captured word
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (WORD_W < 2)
    begin : g_bad_width
        $error("sscr_shifter: WORD_W must be at least 2");
    end

    logic [WORD_W-1:0] shiftFF;
    logic              outFF;

    // ------------------------------------------------------------------
    // Shift in on rising clock while selected
    // ------------------------------------------------------------------
    // Supply reset clears asynchronously, first bit in lands at the top
    always_ff @(posedge lnk.serialClk or negedge lnk.supplyRstn)
    begin
        if (!lnk.supplyRstn)
            shiftFF <= '0;
        else if (!lnk.selectN)
            shiftFF <= {shiftFF[WORD_W-2:0], lnk.serialIn};
    end

    // ------------------------------------------------------------------
    // Serial output updated on falling clock, held while deselected
    // ------------------------------------------------------------------
    always_ff @(negedge lnk.serialClk or negedge lnk.supplyRstn)
    begin
        if (!lnk.supplyRstn)
            outFF <= 1'b0;
        else if (!lnk.selectN)
            outFF <= shiftFF[WORD_W-1];
    end

    assign lnk.serialOut = outFF;
    assign lnk.word      = shiftFF;

endmodule

// [rtl/sscr_top.sv]
// Serially loaded eight-switch control latch with an Avalon-MM status port
`timescale 1ns/1ps
`include "sscr_cfg.svh"
module sscr_top
    import sscr_pkg::*;
#(
    parameter int WORD_W = `SSCR_WORD_BITS,
    parameter int CNT_W  = `SSCR_CNT_BITS
)
(
    input  wire logic                        clk_sys,          // System clock
    input  wire logic                        rstn,             // Sync reset, low
    input  wire logic                        serialClk,        // Link clock pin
    input  wire logic                        selectN,          // Select pin, low
    input  wire logic                        serialIn,         // Serial data in
    input  wire logic                        logicSupplyRstn,  // Supply reset, low
    output      logic                        serialOut,        // Serial data out
    output      logic [WORD_W-1:0]           switchClose,      // 1 closes switch n
    input  wire logic [`SSCR_ADDR_BITS-1:0]  avs_address,      // Byte address
    input  wire logic                        avs_read,         // Read request
    input  wire logic                        avs_write,        // Write request
    input  wire logic [`SSCR_DATA_BITS-1:0]  avs_writedata,    // Write data
    input  wire logic [`SSCR_BE_BITS-1:0]    avs_byteenable,   // Byte lanes
    output      logic [`SSCR_DATA_BITS-1:0]  avs_readdata,     // Read data
    output      logic                        avs_waitrequest   // Stall, high
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // Both widths must leave at least one zero-fill bit in the read word,
    // since an empty replication cannot be built
    if (WORD_W < 2 || WORD_W >= `SSCR_DATA_BITS)
    begin : g_bad_word
        $error("sscr_top: WORD_W out of range");
    end
    if (CNT_W < 1 || CNT_W >= `SSCR_DATA_BITS)
    begin : g_bad_cnt
        $error("sscr_top: CNT_W out of range");
    end

    // ------------------------------------------------------------------
    // Link side shifter
    // ------------------------------------------------------------------
    // Pins reach the shifter unsynchronised, it runs on the link clock itself
    sscr_link_if #(.WORD_W(WORD_W)) lnk ();

    assign lnk.serialClk  = serialClk;
    assign lnk.selectN    = selectN;
    assign lnk.serialIn   = serialIn;
    assign lnk.supplyRstn = logicSupplyRstn;
    assign serialOut      = lnk.serialOut;   // Driven straight by the shifter flop

    sscr_shifter #(.WORD_W(WORD_W)) u_shifter
    (
        .lnk (lnk.shifter)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic selMetaFF;
    logic selSyncFF;
    logic clkMetaFF;
    logic clkSyncFF;
    logic supMetaFF;
    logic supSyncFF;
    logic selPrevFF;

    // Two flops per pin, second flop is the only reader of the first

    // Select pin and its edge history, idle high so no false rise
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            selMetaFF <= 1'b1;
            selSyncFF <= 1'b1;
            selPrevFF <= 1'b1;
        end
        else
        begin
            selMetaFF <= selectN;
            selSyncFF <= selMetaFF;
            selPrevFF <= selSyncFF;
        end
    end

    // Link clock level, idle low like the parked host clock
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            clkMetaFF <= 1'b0;
            clkSyncFF <= 1'b0;
        end
        else
        begin
            clkMetaFF <= serialClk;
            clkSyncFF <= clkMetaFF;
        end
    end

    // Supply reset pin, reads as asserted until flushed
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            supMetaFF <= 1'b0;
            supSyncFF <= 1'b0;
        end
        else
        begin
            supMetaFF <= logicSupplyRstn;
            supSyncFF <= supMetaFF;
        end
    end

    // ------------------------------------------------------------------
    // Decoded link events
    // ------------------------------------------------------------------
    // Select rise lags the pin by two system clocks, as does the clock level,
    // so both are judged on the same delayed picture of the link
    wire selRise   = selSyncFF & ~selPrevFF;
    wire supplyLow = ~supSyncFF;

    // ------------------------------------------------------------------
    // Latch update sequencer
    // ------------------------------------------------------------------
    sscr_state_t stateFF;
    sscr_state_t nxt_state;
    logic        doUpdate;

    // Postpones the copy until the clock has fallen
    // Idle waits for select, selected waits for its rise, pending waits
    // for the clock to fall; a new select while pending drops the update
    // Copying with the clock high would race a late rising link edge
    always_comb
    begin
        nxt_state = stateFF;
        doUpdate  = 1'b0;
        case (stateFF)
            ST_IDLE:
            begin
                if (!selSyncFF)
                    nxt_state = ST_SELECTED;
            end
            ST_SELECTED:
            begin
                if (selRise && !clkSyncFF)
                begin
                    doUpdate  = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else if (selRise)
                    nxt_state = ST_PENDING;
            end
            ST_PENDING:
            begin
                if (!selSyncFF)
                    nxt_state = ST_SELECTED;
                else if (!clkSyncFF)
                begin
                    doUpdate  = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State register, cleared by either reset
    // Supply reset abandons any pending update
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || supplyLow)
            stateFF <= ST_IDLE;
        else
            stateFF <= nxt_state;
    end

    // ------------------------------------------------------------------
    // Register bus handshake
    // ------------------------------------------------------------------
    logic                       waitFF;
    logic [`SSCR_DATA_BITS-1:0] rdataFF;

    // Every request stalls exactly one cycle: taken while waitFF is high,
    // answered while it is low; writes act on the answer edge only
    wire busReq    = avs_read | avs_write;
    wire busAccept = busReq & waitFF;
    wire wrDone    = avs_write & ~waitFF;
    wire rdCapture = busAccept & avs_read;

    // Address decode, one hit per mapped offset
    wire hitSwitch = (avs_address == `SSCR_OFS_SWITCH_STATE);
    wire hitStatus = (avs_address == `SSCR_OFS_STATUS);
    wire hitCtrl   = (avs_address == `SSCR_OFS_CONTROL);
    wire hitCount  = (avs_address == `SSCR_OFS_UPDATE_COUNT);

    // Open-all command, byte lane 0 only
    wire openAllCmd = wrDone & hitCtrl & avs_byteenable[0]
                    & avs_writedata[`SSCR_CTRL_OPEN_ALL];

    // ------------------------------------------------------------------
    // Switch latch and update counter
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] latchFF;
    logic [CNT_W-1:0]  countFF;

    // Link word is stable while deselected, so it is taken directly:
    // the copy only fires once select has been high for two system
    // clocks, and no rising link clock can shift while select is high
    // Update beats a simultaneous software open-all
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || supplyLow)
            latchFF <= '0;
        else if (doUpdate)
            latchFF <= lnk.word;
        else if (openAllCmd)
            latchFF <= '0;
    end

    // Counts completed latch updates, wraps
    // Not cleared by the supply reset, so updates can be counted across it
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            countFF <= '0;
        else if (doUpdate)
            countFF <= countFF + CNT_W'(1);
    end

    // Switch drive is the latch flop itself
    assign switchClose = latchFF;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    logic [`SSCR_DATA_BITS-1:0] statusWord;
    logic [`SSCR_DATA_BITS-1:0] switchWord;
    logic [`SSCR_DATA_BITS-1:0] countWord;
    logic [`SSCR_DATA_BITS-1:0] rdMux;

    // Status bits from the synchronised pins and the sequencer
    always_comb
    begin
        statusWord = `SSCR_DATA_RST;
        statusWord[`SSCR_STAT_SELECTED]  = ~selSyncFF;
        statusWord[`SSCR_STAT_PENDING]   = (stateFF == ST_PENDING);
        statusWord[`SSCR_STAT_CLK_LEVEL] = clkSyncFF;
    end

    // Zero-filled read words; unmapped and write-only offsets read zero
    assign switchWord = {{(`SSCR_DATA_BITS-WORD_W){1'b0}}, latchFF};
    assign countWord  = {{(`SSCR_DATA_BITS-CNT_W){1'b0}}, countFF};
    assign rdMux      = hitSwitch ? switchWord :
                        hitStatus ? statusWord :
                        hitCount  ? countWord  : `SSCR_DATA_RST;

    // ------------------------------------------------------------------
    // Bus answer: waitrequest drops for one cycle per request
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            waitFF  <= 1'b1;
            rdataFF <= `SSCR_DATA_RST;
        end
        else
        begin
            waitFF  <= ~busAccept;
            if (rdCapture)
                rdataFF <= rdMux;
        end
    end

    // Bus outputs come straight from their flops
    assign avs_waitrequest = waitFF;
    assign avs_readdata    = rdataFF;

endmodule

// [tb/sscr_top_checker.sv]
// Port assertions for the switch controller
`timescale 1ns/1ps
module sscr_top_checker
#(
    parameter int WORD_W = 8,
    parameter int CNT_W  = 16
)
(
    input wire logic              clk_sys,          // Clock
    input wire logic              rstn,             // Reset
    input wire logic              serialClk,        // Link clock
    input wire logic              selectN,          // Select
    input wire logic              serialIn,         // Data in
    input wire logic              logicSupplyRstn,  // Supply reset
    input wire logic              serialOut,        // Data out
    input wire logic [WORD_W-1:0] switchClose,      // Switches
    input wire logic [3:0]        avs_address,      // Address
    input wire logic              avs_read,         // Read
    input wire logic              avs_write,        // Write
    input wire logic [31:0]       avs_writedata,    // Write data
    input wire logic [3:0]        avs_byteenable,   // Lanes
    input wire logic [31:0]       avs_readdata,     // Read data
    input wire logic              avs_waitrequest   // Stall
);
    // ------------------------
    // Checks on system clock
    // ------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Switches hold unless software or supply reset moved them
    property p_hold(c);
        c && logicSupplyRstn && !$past(avs_write) && !$past(avs_write, 2)
            |-> $stable(switchClose);
    endproperty
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
    a_sel_hold: assert property (p_hold(!selectN && $past(!selectN, 4)))
        else $error("switches moved while selected");
    a_clk_high: assert property (p_hold(serialClk && $past(serialClk, 4)))
        else $error("update while clock high");
    a_upd_after: assert property ($changed(switchClose) && logicSupplyRstn
        && !$past(avs_write) && !$past(avs_write, 2)
        |-> $past(selectN) && $past(selectN, 2) && $past(selectN, 3))
        else $error("update without select rise");
    a_sup_open: assert property (!logicSupplyRstn [*4] |-> switchClose == '0)
        else $error("supply reset left switches closed");
    a_sup_out: assert property (!logicSupplyRstn && $past(!logicSupplyRstn)
        |-> !serialOut) else $error("supply reset left output set");
    a_desel_out: assert property (selectN && $past(selectN) && logicSupplyRstn
        && $past(logicSupplyRstn) |-> $stable(serialOut)) else $error("output moved");
    a_out_fall: assert property ($changed(serialOut) && logicSupplyRstn
        && $past(logicSupplyRstn) |-> !serialClk) else $error("output not on fall");
    // Main scenarios seen
    c_update: cover property ($changed(switchClose) && logicSupplyRstn);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_supply: cover property ($fell(logicSupplyRstn));
endmodule

// [tb/sscr_host_model.sv]
// Serial host model for the switch controller link
`timescale 1ns/1ps
module sscr_host_model
(
    output logic      serialClk,  // Link clock
    output logic      selectN,    // Select, low
    output logic      serialIn,   // Data to device
    input  wire logic serialOut   // Data from device
);
    // Idle: deselected, clock parked low
    initial
    begin
        serialClk = 1'b0;
        selectN = 1'b1;
        serialIn = 1'b0;
    end
    // Shift n bits msb first, collect bits seen on the output
    task automatic frame(input logic [15:0] bits, input int n, input bit hiAtRise,
                         output logic [15:0] got);
        #1.3;
        got = '0;
        selectN = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serialIn = bits[i];
            #32;
            got[i] = serialOut;
            serialClk = 1'b1;
            #32;
            if (i > 0 || !hiAtRise)
                serialClk = 1'b0;
        end
        #32;
        selectN = 1'b1;
        if (hiAtRise)
        begin
            #64;
            serialClk = 1'b0;
        end
        serialIn = ~serialIn; // Released line shows inverse
        #32;
    endtask
    // Clock and data wiggle while deselected
    task automatic noise();
        #1.3;
        repeat (3)
        begin
            serialIn = ~serialIn;
            #32 serialClk = 1'b1;
            #32 serialClk = 1'b0;
        end
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the serial switch controller
`timescale 1ns/1ps
`include "sscr_cfg.svh"
module tb_top;
    logic        clk_sys, rstn, serialClk, selectN, serialIn, logicSupplyRstn;
    logic        serialOut, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  switchClose;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] got;
    int          fail_count, n_tests, cycles;

    sscr_top dut (.clk_sys(clk_sys), .rstn(rstn), .serialClk(serialClk),
        .selectN(selectN), .serialIn(serialIn), .logicSupplyRstn(logicSupplyRstn),
        .serialOut(serialOut), .switchClose(switchClose), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sscr_host_model host (.serialClk(serialClk), .selectN(selectN),
        .serialIn(serialIn), .serialOut(serialOut));

    // Clock and run limit
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One bus request, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic load(input logic [15:0] b, input int n, input bit hi);
        host.frame(b, n, hi, got);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_load();
        load(16'h00A5, 8, 1'b0);
        chk(switchClose, 32'h0000_00A5);
        bus(1'b0, `SSCR_OFS_SWITCH_STATE, 32'h0000_0000);
        chk(rd, 32'h0000_00A5);
        bus(1'b0, `SSCR_OFS_UPDATE_COUNT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        $display("load done");
    endtask
    task automatic t_regs();
        bus(1'b1, `SSCR_OFS_CONTROL, 32'h0000_0001);
        @(posedge clk_sys);
        chk(switchClose, 32'h0000_0000);
        bus(1'b0, `SSCR_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, `SSCR_OFS_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("regs done");
    endtask
    task automatic t_shift();
        load(16'h3C96, 16, 1'b0);
        chk(got, 32'h0000_A53C);
        chk(switchClose, 32'h0000_0096);
        load(16'h000F, 4, 1'b0);
        chk(got, 32'h0000_0009);
        chk(switchClose, 32'h0000_006F);
        load(16'h0081, 8, 1'b1);
        chk(switchClose, 32'h0000_0081);
        $display("shift done");
    endtask
    task automatic t_ignore();
        host.noise();
        chk(switchClose, 32'h0000_0081);
        load(16'h005A, 8, 1'b0);
        chk(got, 32'h0000_0081);
        chk(switchClose, 32'h0000_005A);
        $display("ignore done");
    endtask
    task automatic t_supply();
        logicSupplyRstn <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(switchClose, 32'h0000_0000);
        chk(serialOut, 32'h0000_0000);
        logicSupplyRstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        load(16'h0000, 8, 1'b0);
        chk(got, 32'h0000_0000);
        bus(1'b0, `SSCR_OFS_UPDATE_COUNT, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        $display("supply done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reset, then scenarios in order
    initial
    begin
        rstn = 1'b0;
        logicSupplyRstn = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        @(posedge clk_sys);
        logicSupplyRstn <= 1'b0; // Clean falling edge clears the link flops
        repeat (19) @(posedge clk_sys);
        rstn <= 1'b1;
        logicSupplyRstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(switchClose, 32'h0000_0000);
        t_load();
        t_regs();
        t_shift();
        t_ignore();
        t_supply();
        tally_and_finish();
    end
endmodule
bind sscr_top sscr_top_checker #(.WORD_W(WORD_W), .CNT_W(CNT_W)) chk_i (
    .clk_sys(clk_sys), .rstn(rstn), .serialClk(serialClk), .selectN(selectN),
    .serialIn(serialIn), .logicSupplyRstn(logicSupplyRstn), .serialOut(serialOut),
    .switchClose(switchClose), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
